/* File: logic/dcg_consts.svh */
// Purpose: Named offsets, fields, codes and timing for the drive run/trip guard
// Assumes: 40 MHz mclk, byte-addressed register port with 32-bit data
// Notes:   Definitions only; included by bare name
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH

// Clock
`define DCG_CLK_PERIOD_NS   25

// Register byte offsets
`define DCG_ADDR_W          8
`define DCG_OFS_CTRL        8'h00
`define DCG_OFS_WAIT        8'h04
`define DCG_OFS_STATUS      8'h08
`define DCG_OFS_CMD         8'h0C

// Control register fields
`define DCG_CTRL_W          4
`define DCG_CTRL_RESET      4'h0
`define DCG_CTRL_SPEED_BIT  0
`define DCG_CTRL_GUARD_BIT  1
`define DCG_CTRL_CINV_BIT   2
`define DCG_CTRL_FINV_BIT   3

// Restart wait register: count of wait ticks
`define DCG_WAIT_W          8
`define DCG_WAIT_RESET      8'h00
`define DCG_WAIT_ZERO       8'h00
`define DCG_WAIT_TICK_MS    100
`define DCG_NS_PER_MS       1000000

// Command register fields
`define DCG_CMD_KPRST_BIT   0

// Status register layout
`define DCG_STAT_STATE_LSB  0
`define DCG_STAT_ALARM_BIT  6
`define DCG_STAT_DRIVE_BIT  7
`define DCG_STAT_EDGE_BIT   8
`define DCG_STAT_CODE_LSB   16

// Trip codes shown on the display
`define DCG_CODE_NONE       8'h00
`define DCG_CODE_UV         8'h09
`define DCG_CODE_EXT        8'h0C
`define DCG_CODE_GUARD      8'h0D

// Cycles allowed for the pin synchronisers to fill after reset
`define DCG_SETTLE_W        2
`define DCG_SETTLE_LAST     2'h3

`endif

/* File: logic/dcg_pkg.sv */
// Purpose: Types shared by the drive run/trip guard
// Assumes: Constants come from dcg_consts.svh
// Notes:   State codes are one-hot
package dcg_pkg;

  // Terminal inputs, as wired
  typedef struct packed {
    logic forwardRun;   // Forward run terminal
    logic reverseRun;   // Reverse run terminal
    logic coastStop;    // Coast stop terminal, raw polarity
    logic extFault;     // External fault terminal, raw polarity
    logic faultClear;   // Reset terminal, normally open only
    logic underVolt;    // Undervoltage detector level
  } dcg_pins_s;

  // Software settings
  typedef struct packed {
    logic faultInvert;  // External fault active on open contact
    logic coastInvert;  // Coast stop active on open contact
    logic startGuard;   // Power-up start guard enable
    logic speedSelect;  // Resume from motor speed, else from 0 Hz
  } dcg_ctrl_s;

  // Sequencer states
  typedef enum logic [5:0] {
    DCG_INIT  = 6'h01,
    DCG_STOP  = 6'h02,
    DCG_RUN   = 6'h04,
    DCG_COAST = 6'h08,
    DCG_WAIT  = 6'h10,
    DCG_TRIP  = 6'h20
  } dcg_state_e;

endpackage

/* File: logic/dcg_sync.sv */
// Purpose: Two-flop synchroniser for a group of terminal inputs
// Assumes: Inputs asynchronous to mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module dcg_sync #(
  parameter int W = 6
) (
  input  wire logic         mclk,   // Control clock
  input  wire logic         rst_n,  // Synchronous reset, active low
  input  wire logic [W-1:0] din,    // Asynchronous levels
  output logic      [W-1:0] dout    // Levels in mclk domain
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  // Shift one stage per clock; cleared by reset
  always_comb begin
    next_stage1 = rst_n ? din : '0;
    next_dout   = rst_n ? stage1 : '0;
  end

  always_ff @(posedge mclk) begin
    stage1 <= next_stage1;
    dout   <= next_dout;
  end

endmodule // dcg_sync

/* File: logic/dcg_guard.sv */
// Purpose: Run permission and trip sequencing for a motor drive
// Assumes: Terminal levels arrive raw; mclk 40 MHz; rst_n is power-up reset
// Notes:   Ramp and speed matching live downstream; this block gates output
//
// How it works
// - Coast input held forces output off, after one cycle on when run starts from power-up or a reset
// - Coast release resumes only with run active
// - Setting picks resume from 0 Hz or speed
// - Wait time before resume; zero means none
// - Coast input polarity selectable in software
// - Fault input rising edge latches trip, output off
// - Fault release neither clears nor re-trips
// - Only reset clears fault trip, then stop if guarded or run off
// - Fault trip coasts motor, alarm at once
// - Unguarded: after clear, run if command active
// - Guarded: after fault clear, need fresh run or reset
// - Guarded power-up with run active trips
// - Guard trip cleared by run off or reset
// - Reset clears guard trip, run starts immediately
// - Unguarded power-up honours active run command
// - Undervoltage clear still applies the start guard
// - Forward and reverse together means stop
// - Reset pulse completed cancels any trip, except a guarded undervoltage trip with run active becomes a guard trip
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "dcg_consts.svh"
module dcg_guard #(
  parameter int unsigned TICK_CYCLES =
    (`DCG_WAIT_TICK_MS * `DCG_NS_PER_MS) / `DCG_CLK_PERIOD_NS  // Cycles per wait tick
) (
  input  wire logic                   mclk,            // Control clock, 40 MHz
  input  wire logic                   rst_n,           // Power-up reset, active low
  input  wire dcg_pkg::dcg_pins_s     pins,            // Terminal levels, raw
  input  wire logic [`DCG_ADDR_W-1:0] regAddr,         // Register byte address
  input  wire logic [31:0]            regWdata,        // Register write data
  input  wire logic                   regWr,           // Write strobe
  input  wire logic                   regRd,           // Read strobe
  output logic      [31:0]            regRdata,        // Read data, cycle after strobe
  output logic                        driveEnable,     // Motor output on
  output logic                        runReverse,      // Direction while running
  output logic                        startPulse,      // One cycle at each start
  output logic                        resumeFromSpeed, // Start matches motor speed
  output logic                        alarm,           // Trip alarm
  output logic      [7:0]             tripCode         // Code for the display
);

  // Synchronised terminals
  dcg_pkg::dcg_pins_s syncPins;
  dcg_pkg::dcg_pins_s prevPins;
  dcg_pkg::dcg_pins_s next_prevPins;

  dcg_sync #(
    .W ($bits(dcg_pkg::dcg_pins_s))
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (pins),
    .dout  (syncPins)
  );

  // Register state
  dcg_pkg::dcg_ctrl_s    ctrl;
  dcg_pkg::dcg_ctrl_s    next_ctrl;
  logic [`DCG_WAIT_W-1:0] waitTime;
  logic [`DCG_WAIT_W-1:0] next_waitTime;
  logic [31:0]            next_regRdata;
  logic [31:0]            statusWord;
  logic                   kpReset;

  // Sequencer state
  dcg_pkg::dcg_state_e     state;
  dcg_pkg::dcg_state_e     next_state;
  logic [7:0]              next_tripCode;
  logic                    needEdge;
  logic                    next_needEdge;
  logic [`DCG_WAIT_W-1:0]  waitCnt;
  logic [`DCG_WAIT_W-1:0]  next_waitCnt;
  logic [31:0]             tickCnt;
  logic [31:0]             next_tickCnt;
  logic [`DCG_SETTLE_W-1:0] settle;
  logic [`DCG_SETTLE_W-1:0] next_settle;
  logic                    next_driveEnable;
  logic                    next_runReverse;
  logic                    next_startPulse;
  logic                    next_resumeFromSpeed;
  logic                    next_alarm;

  // Decoded terminal functions
  logic runCmd;
  logic prevRunCmd;
  logic runRise;
  logic coastAct;
  logic extAct;
  logic prevExtAct;
  logic extRise;
  logic clrFall;
  logic uvRise;
  logic resetOp;

  // Both directions at once reads as stop
  assign runCmd     = syncPins.forwardRun ^ syncPins.reverseRun;
  assign prevRunCmd = prevPins.forwardRun ^ prevPins.reverseRun;
  assign runRise    = runCmd & ~prevRunCmd;
  // Polarity applied after the synchroniser so a change of setting is clean
  assign coastAct   = syncPins.coastStop ^ ctrl.coastInvert;
  assign extAct     = syncPins.extFault ^ ctrl.faultInvert;
  assign prevExtAct = prevPins.extFault ^ ctrl.faultInvert;
  // Only the off-to-on edge trips; the release is ignored
  assign extRise    = extAct & ~prevExtAct;
  // The reset acts on release, so a held terminal clears nothing yet
  assign clrFall    = prevPins.faultClear & ~syncPins.faultClear;
  assign uvRise     = syncPins.underVolt & ~prevPins.underVolt;
  // Keypad reset is a write of one to the command register
  assign kpReset    = regWr & (regAddr == `DCG_OFS_CMD) & regWdata[`DCG_CMD_KPRST_BIT];
  assign resetOp    = clrFall | kpReset;

  // Edge history of the synchronised terminals
  always_comb begin
    next_prevPins = rst_n ? syncPins : '0;
  end

  always_ff @(posedge mclk) begin
    prevPins <= next_prevPins;
  end

  // Register writes and read data
  always_comb begin
    statusWord = '0;
    statusWord[`DCG_STAT_STATE_LSB +: 6]  = state;
    statusWord[`DCG_STAT_ALARM_BIT]        = alarm;
    statusWord[`DCG_STAT_DRIVE_BIT]        = driveEnable;
    statusWord[`DCG_STAT_EDGE_BIT]         = needEdge;
    statusWord[`DCG_STAT_CODE_LSB +: 8]    = tripCode;
    next_ctrl     = ctrl;
    next_waitTime = waitTime;
    next_regRdata = '0;
    if (regWr && regAddr == `DCG_OFS_CTRL) begin
      next_ctrl = dcg_pkg::dcg_ctrl_s'(regWdata[`DCG_CTRL_W-1:0]);
    end
    if (regWr && regAddr == `DCG_OFS_WAIT) begin
      next_waitTime = regWdata[`DCG_WAIT_W-1:0];
    end
    if (regRd) begin
      unique case (regAddr)
        `DCG_OFS_CTRL:   next_regRdata = {28'h0000000, ctrl};
        `DCG_OFS_WAIT:   next_regRdata = {24'h000000, waitTime};
        `DCG_OFS_STATUS: next_regRdata = statusWord;
        default:         next_regRdata = '0;  // Command and unmapped read zero
      endcase
    end
    if (!rst_n) begin
      next_ctrl     = dcg_pkg::dcg_ctrl_s'(`DCG_CTRL_RESET);
      next_waitTime = `DCG_WAIT_RESET;
      next_regRdata = '0;
    end
  end

  always_ff @(posedge mclk) begin
    ctrl     <= next_ctrl;
    waitTime <= next_waitTime;
    regRdata <= next_regRdata;
  end

  // Run and trip sequencer
  // Trips are checked after the state case so they override any transition out of STOP, RUN, COAST or WAIT.
  always_comb begin
    next_state           = state;
    next_tripCode        = tripCode;
    next_needEdge        = needEdge;
    next_waitCnt         = waitCnt;
    next_tickCnt         = tickCnt;
    next_settle          = settle;
    next_runReverse      = runReverse;
    next_startPulse      = 1'b0;
    next_resumeFromSpeed = resumeFromSpeed;
    unique case (state)
      dcg_pkg::DCG_INIT: begin
        // Let the synchronisers fill before judging the run command
        if (settle == `DCG_SETTLE_LAST) begin
          if (runCmd && ctrl.startGuard) begin
            next_state    = dcg_pkg::DCG_TRIP;
            next_tripCode = `DCG_CODE_GUARD;
          end else if (runCmd) begin
            next_state           = dcg_pkg::DCG_RUN;
            next_startPulse      = 1'b1;
            next_resumeFromSpeed = 1'b0;
          end else begin
            next_state = dcg_pkg::DCG_STOP;
          end
        end else begin
          next_settle = settle + 1'b1;
        end
      end
      dcg_pkg::DCG_STOP: begin
        // A reset or a fresh run edge re-arms start after a guarded clear
        if (resetOp || runRise) begin
          next_needEdge = 1'b0;
        end
        if (runCmd && !coastAct && !syncPins.faultClear &&
            (!needEdge || runRise || resetOp)) begin
          next_state           = dcg_pkg::DCG_RUN;
          next_startPulse      = 1'b1;
          next_resumeFromSpeed = 1'b0;
        end
      end
      dcg_pkg::DCG_RUN: begin
        if (!runCmd) begin
          next_state = dcg_pkg::DCG_STOP;
        end else if (coastAct) begin
          next_state = dcg_pkg::DCG_COAST;
        end
      end
      dcg_pkg::DCG_COAST: begin
        // Resume only if run is still present at release
        if (!coastAct) begin
          if (!runCmd) begin
            next_state = dcg_pkg::DCG_STOP;
          end else if (waitTime == `DCG_WAIT_ZERO) begin
            next_state           = dcg_pkg::DCG_RUN;
            next_startPulse      = 1'b1;
            next_resumeFromSpeed = ctrl.speedSelect;
          end else begin
            next_state   = dcg_pkg::DCG_WAIT;
            next_waitCnt = '0;
            next_tickCnt = '0;
          end
        end
      end
      dcg_pkg::DCG_WAIT: begin
        if (coastAct) begin
          next_state = dcg_pkg::DCG_COAST;
        end else if (!runCmd) begin
          next_state = dcg_pkg::DCG_STOP;
        end else if (waitCnt == waitTime) begin
          next_state           = dcg_pkg::DCG_RUN;
          next_startPulse      = 1'b1;
          next_resumeFromSpeed = ctrl.speedSelect;
        end else if (tickCnt == TICK_CYCLES - 32'd1) begin
          next_tickCnt = '0;
          next_waitCnt = waitCnt + 1'b1;
        end else begin
          next_tickCnt = tickCnt + 32'd1;
        end
      end
      dcg_pkg::DCG_TRIP: begin
        if (tripCode == `DCG_CODE_GUARD) begin
          if (!runCmd) begin
            next_state    = dcg_pkg::DCG_STOP;
            next_tripCode = `DCG_CODE_NONE;
          end else if (resetOp) begin
            next_state           = dcg_pkg::DCG_RUN;
            next_tripCode        = `DCG_CODE_NONE;
            next_startPulse      = 1'b1;
            next_resumeFromSpeed = 1'b0;
          end
        end else if (resetOp) begin
          next_tripCode = `DCG_CODE_NONE;
          if (tripCode == `DCG_CODE_UV && runCmd && ctrl.startGuard) begin
            next_state    = dcg_pkg::DCG_TRIP;
            next_tripCode = `DCG_CODE_GUARD;
          end else if (tripCode == `DCG_CODE_EXT && ctrl.startGuard) begin
            next_state    = dcg_pkg::DCG_STOP;
            next_needEdge = 1'b1;
          end else if (runCmd) begin
            next_state           = dcg_pkg::DCG_RUN;
            next_startPulse      = 1'b1;
            next_resumeFromSpeed = 1'b0;
          end else begin
            next_state = dcg_pkg::DCG_STOP;
          end
        end
      end
      default: begin
        next_state    = dcg_pkg::DCG_STOP;
        next_tripCode = `DCG_CODE_NONE;
      end
    endcase
    // New trips; an existing trip keeps its code until cleared
    if (state != dcg_pkg::DCG_INIT && state != dcg_pkg::DCG_TRIP) begin
      if (extRise) begin
        next_state      = dcg_pkg::DCG_TRIP;
        next_tripCode   = `DCG_CODE_EXT;
        next_startPulse = 1'b0;
      end else if (uvRise) begin
        next_state      = dcg_pkg::DCG_TRIP;
        next_tripCode   = `DCG_CODE_UV;
        next_startPulse = 1'b0;
      end
    end
    if (next_state == dcg_pkg::DCG_RUN) begin
      next_runReverse = syncPins.reverseRun;
    end
    if (!rst_n) begin
      next_state           = dcg_pkg::DCG_INIT;
      next_tripCode        = `DCG_CODE_NONE;
      next_needEdge        = 1'b0;
      next_waitCnt         = '0;
      next_tickCnt         = '0;
      next_settle          = '0;
      next_runReverse      = 1'b0;
      next_startPulse      = 1'b0;
      next_resumeFromSpeed = 1'b0;
    end
  end

  // Output follows the next state so a trip cuts it in the same edge.
  // A held reset terminal also coasts the motor.
  always_comb begin
    next_driveEnable = rst_n && next_state == dcg_pkg::DCG_RUN &&
                       !syncPins.faultClear;
    next_alarm       = rst_n && next_state == dcg_pkg::DCG_TRIP;
  end

  always_ff @(posedge mclk) begin
    state           <= next_state;
    tripCode        <= next_tripCode;
    needEdge        <= next_needEdge;
    waitCnt         <= next_waitCnt;
    tickCnt         <= next_tickCnt;
    settle          <= next_settle;
    runReverse      <= next_runReverse;
    startPulse      <= next_startPulse;
    resumeFromSpeed <= next_resumeFromSpeed;
    driveEnable     <= next_driveEnable;
    alarm           <= next_alarm;
  end

endmodule // dcg_guard

/* File: testbench/dcg_guard_checker.sv */
// Purpose: Port assertions for the run/trip guard
// Assumes: Sees only the dcg_guard ports; invert bits shadowed from writes
// Notes:   Pin effects show three edges after the pin is sampled
`timescale 1ns/100ps
module dcg_guard_checker (
  input wire logic               mclk,            // Control clock
  input wire logic               rst_n,           // Reset, active low
  input wire dcg_pkg::dcg_pins_s pins,            // Terminal levels
  input wire logic [7:0]         regAddr,         // Register address
  input wire logic [31:0]        regWdata,        // Write data
  input wire logic               regWr,           // Write strobe
  input wire logic               regRd,           // Read strobe
  input wire logic [31:0]        regRdata,        // Read data
  input wire logic               driveEnable,     // Motor output on
  input wire logic               runReverse,      // Direction
  input wire logic               startPulse,      // Start pulse
  input wire logic               resumeFromSpeed, // Resume mode
  input wire logic               alarm,           // Trip alarm
  input wire logic [7:0]         tripCode         // Display code
);
  logic [3:0] clrAge;
  logic [3:0] next_clrAge;
  logic       cinv;
  logic       next_cinv;
  logic       finv;
  logic       next_finv;

  // Age since the reset terminal was last high or any register write; a trip other than a guard trip may only drop soon after one
  always_comb begin
    next_clrAge = clrAge + {3'h0, clrAge != 4'hF};
    if (pins.faultClear || regWr) next_clrAge = 4'h0;
    next_cinv = (regWr && regAddr == 8'h00) ? regWdata[2] : cinv;
    next_finv = (regWr && regAddr == 8'h00) ? regWdata[3] : finv;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clrAge <= 4'hF;
      cinv <= 1'b0;
      finv <= 1'b0;
    end else begin
      clrAge <= next_clrAge;
      cinv <= next_cinv;
      finv <= next_finv;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  trip_off_a : assert property (alarm |-> !driveEnable)
    else $error("drive on while tripped");
  ext_trip_a : assert property (
    $rose(pins.extFault) && !finv && !alarm && clrAge == 4'hF
    |-> ##3 alarm && tripCode == 8'h0C && !driveEnable) else $error("no trip on fault edge");
  trip_hold_a : assert property (
    $fell(alarm) && $past(tripCode) != 8'h0D |-> clrAge < 4'h8)
    else $error("trip dropped without reset");
  both_dirs_a : assert property (
    (pins.forwardRun && pins.reverseRun) [*4] |=> !driveEnable)
    else $error("drive on with both directions");
  clear_held_a : assert property (pins.faultClear [*4] |=> !driveEnable)
    else $error("drive on while reset held");
  coast_off_a : assert property ((!cinv && pins.coastStop) [*4] |=> !driveEnable)
    else $error("drive on while coasting");
  start_edge_a : assert property (startPulse |-> driveEnable && !$past(driveEnable))
    else $error("start pulse without drive rise");
  code_valid_a : assert property (alarm |-> tripCode inside {8'h09, 8'h0C, 8'h0D})
    else $error("bad trip code");
  code_clear_a : assert property (!alarm |-> tripCode == 8'h00)
    else $error("code left after clear");

  cover property (startPulse && resumeFromSpeed);
  cover property ($rose(alarm) && tripCode == 8'h0D);
  cover property ($fell(alarm) ##[1:8] startPulse);
endmodule // dcg_guard_checker

/* File: testbench/dcg_plc_model.sv */
// Purpose: Controlling PLC contacts on the drive terminals
// Assumes: Bench sets wanted levels; contacts move one edge later
// Notes:   With holdOff set, run stays off through the power-up window
`timescale 1ns/100ps
module dcg_plc_model #(
  parameter int HOLD_CYCLES = 40 // Scaled power-up run delay
) (
  input  wire logic               mclk,    // Control clock
  input  wire logic               rst_n,   // Power-up reset, active low
  input  wire logic               holdOff, // Delay run after power-up
  input  wire dcg_pkg::dcg_pins_s want,    // Wanted contact levels
  output dcg_pkg::dcg_pins_s      pins     // Terminal levels
);
  int upCnt;

  initial pins = '0;
  // Time since power-up, saturating at the window
  always @(posedge mclk) begin
    if (!rst_n) upCnt <= 0;
    else if (upCnt < HOLD_CYCLES) upCnt <= upCnt + 1;
  end
  // Contacts follow the wanted levels; a guarded drive must not see run too early
  always @(posedge mclk) begin
    pins <= want;
    if (holdOff && upCnt < HOLD_CYCLES) begin
      pins.forwardRun <= 1'b0;
      pins.reverseRun <= 1'b0;
    end
  end
endmodule // dcg_plc_model

/* File: testbench/test_dcg_guard.sv */
// Purpose: Self-checking bench for the run/trip guard
// Assumes: Wait tick shortened to 4 cycles; terminals come from the PLC model
// Notes:   Register reads are checked from a queue by a separate monitor
`timescale 1ns/100ps
module test_dcg_guard;
  localparam int TICK = 4;
  localparam logic [31:0] S_RUN = 32'h0000_0084, S_STOP = 32'h0000_0002;
  localparam logic [31:0] S_COAST = 32'h0000_0008, S_EDGE = 32'h0000_0102;
  localparam logic [31:0] S_EXT = 32'h000C_0060, S_GRD = 32'h000D_0060;
  logic               mclk, rst_n, regWr, regRd, holdOff;
  logic [7:0]         regAddr, tripCode;
  logic [31:0]        regWdata, regRdata;
  logic               driveEnable, runReverse, startPulse, resumeFromSpeed, alarm;
  logic               rdLast = 1'b0;
  dcg_pkg::dcg_pins_s want, pins;
  logic [31:0]        expQ[$];
  int                 badCount = 0;
  int                 checked = 0;

  dcg_plc_model u_plc (.mclk(mclk), .rst_n(rst_n), .holdOff(holdOff), .want(want), .pins(pins));
  dcg_guard #(.TICK_CYCLES(TICK)) u_dut (.mclk(mclk), .rst_n(rst_n), .pins(pins),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .driveEnable(driveEnable), .runReverse(runReverse),
    .startPulse(startPulse), .resumeFromSpeed(resumeFromSpeed), .alarm(alarm),
    .tripCode(tripCode));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("checked=%0d badCount=%0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus tasks start just after an edge and end on one, strobes never overlap
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic waitDrive(input logic v, input int n);
    for (int i = 0; i < n && driveEnable !== v; i++) @(posedge mclk);
    chk("driveEnable", {31'h0, v}, {31'h0, driveEnable});
  endtask
  task automatic pulseClr;
    want.faultClear <= 1'b1;
    repeat (4) @(posedge mclk);
    want.faultClear <= 1'b0;
  endtask
  // Power-up with a control write on the first edge, before the run check
  task automatic powerUp(input logic [3:0] ctrl);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    regAddr <= 8'h00;
    regWdata <= {28'h0, ctrl};
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read words are judged in the cycle after the strobe, oldest note first
  always @(posedge mclk) begin
    if (rdLast) chk("regRdata", expQ.pop_front(), regRdata);
    rdLast <= regRd;
  end

  initial begin
    repeat (4000) @(posedge mclk);
    badCount++;
    report_and_stop();
  end

  initial begin
    int w;
    int t;
    void'($urandom(16));
    {rst_n, regWr, regRd, holdOff, regAddr, regWdata} = '0;
    want = '0;
    want.forwardRun = 1'b1;
    powerUp(4'h0);
    waitDrive(1'b1, 20);
    rd(8'h08, S_RUN);
    want.reverseRun <= 1'b1;
    waitDrive(1'b0, 10);
    rd(8'h08, S_STOP);
    want.reverseRun <= 1'b0;
    waitDrive(1'b1, 10);
    // Swap direction in one step: run stays on, direction follows
    want.forwardRun <= 1'b0;
    want.reverseRun <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("runReverse", 32'h1, {31'h0, runReverse});
    chk("driveEnable", 32'h1, {31'h0, driveEnable});
    want.forwardRun <= 1'b1;
    want.reverseRun <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("runReverse", 32'h0, {31'h0, runReverse});
    // Coast and resume from 0 Hz without wait, then from speed after a random wait
    for (int s = 0; s < 2; s++) begin
      w = (s == 0) ? 0 : $urandom_range(3, 1);
      wr(8'h00, {31'h0, s[0]});
      wr(8'h04, w);
      want.coastStop <= 1'b1;
      waitDrive(1'b0, 6);
      rd(8'h08, S_COAST);
      want.coastStop <= 1'b0;
      for (t = 0; t < 200 && startPulse !== 1'b1; t++) @(posedge mclk);
      chk("resumeFromSpeed", {31'h0, s[0]}, {31'h0, resumeFromSpeed});
      chk("waitSpan", 32'h1, {31'h0, t >= w * TICK + 5 && t <= w * TICK + 10});
    end
    wr(8'h04, 32'h0);
    want.coastStop <= 1'b1;
    repeat (6) @(posedge mclk);
    want.forwardRun <= 1'b0;
    repeat (2) @(posedge mclk);
    want.coastStop <= 1'b0;
    repeat (12) @(posedge mclk);
    rd(8'h08, S_STOP);
    want.forwardRun <= 1'b1;
    waitDrive(1'b1, 10);
    wr(8'h00, 32'h4);
    waitDrive(1'b0, 6);
    rd(8'h08, S_COAST);
    wr(8'h00, 32'h0);
    waitDrive(1'b1, 10);
    // Fault trip while running, unguarded recovery; let the last write age first
    repeat (16) @(posedge mclk);
    want.extFault <= 1'b1;
    waitDrive(1'b0, 6);
    chk("alarm", 32'h1, {31'h0, alarm});
    rd(8'h08, S_EXT);
    want.extFault <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(8'h08, S_EXT);
    pulseClr();
    waitDrive(1'b1, 8);
    rd(8'h08, S_RUN);
    // Inverted fault input: closed contact is healthy, opening it trips
    wr(8'h00, 32'h8);
    want.extFault <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("alarm", 32'h0, {31'h0, alarm});
    want.extFault <= 1'b0;
    waitDrive(1'b0, 6);
    rd(8'h08, S_EXT);
    pulseClr();
    waitDrive(1'b1, 8);
    // Guarded fault recovery needs a fresh run edge or a second reset, here a keypad reset
    wr(8'h00, 32'h2);
    want.extFault <= 1'b1;
    repeat (6) @(posedge mclk);
    want.extFault <= 1'b0;
    pulseClr();
    repeat (10) @(posedge mclk);
    rd(8'h08, S_EDGE);
    wr(8'h0C, 32'h1);
    waitDrive(1'b1, 8);
    want.underVolt <= 1'b1;
    waitDrive(1'b0, 6);
    chk("tripCode", 32'h9, {24'h0, tripCode});
    want.underVolt <= 1'b0;
    pulseClr();
    repeat (6) @(posedge mclk);
    rd(8'h08, S_GRD);
    want.forwardRun <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("alarm", 32'h0, {31'h0, alarm});
    // Guarded power-up with run held, then with the controller holding off
    want.forwardRun <= 1'b1;
    powerUp(4'h2);
    repeat (10) @(posedge mclk);
    rd(8'h08, S_GRD);
    pulseClr();
    waitDrive(1'b1, 8);
    holdOff <= 1'b1;
    powerUp(4'h2);
    waitDrive(1'b1, 60);
    rd(8'h08, S_RUN);
    report_and_stop();
  end
endmodule // test_dcg_guard

bind dcg_guard dcg_guard_checker u_chk (.mclk(mclk), .rst_n(rst_n), .pins(pins),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .driveEnable(driveEnable), .runReverse(runReverse),
  .startPulse(startPulse), .resumeFromSpeed(resumeFromSpeed), .alarm(alarm),
  .tripCode(tripCode));
